// [verilog/ppc_ctrl.sv]
`timescale 1ns/1ns
`default_nettype none

module ppc_ctrl #(
	parameter int unsigned DEBOUNCE_CYC = ppc_pkg::DEBOUNCE_CYC,
	parameter int unsigned INT_MIN_CYC = ppc_pkg::INT_MIN_CYC,
	parameter int unsigned RECOVERY_CYC = ppc_pkg::RECOVERY_CYC,
	parameter int unsigned BLANK_CYC = ppc_pkg::BLANK_CYC,
	parameter int unsigned LONG_PUSH_CYC = ppc_pkg::LONG_PUSH_CYC,
	parameter bit OPT_LONG_RESET = ppc_pkg::OPT_LONG_RESET_DEFAULT,
	parameter bit OPT_EN_INVERT = ppc_pkg::OPT_EN_INVERT_DEFAULT
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// pins from buttons, processor and comparators
	input wire logic i_power_button_n,
	input wire logic i_second_button_n,
	input wire logic i_hold_confirm,
	input wire logic i_above_upper,
	input wire logic i_above_lower,
	// outputs
	output logic o_power_enable,
	output logic o_reset_n,
	output logic o_interrupt_n,
	output logic o_button_state_n,
	output logic o_undervoltage_n,
	output logic o_hold_pulldown,
	output logic o_ref_enable,
	output logic o_standby
);
	typedef enum {
		PPC_OFF,
		PPC_DEBOUNCE,
		PPC_START,
		PPC_RUN
	} ppc_state_e;

	localparam int unsigned LONG_CYC = DEBOUNCE_CYC + INT_MIN_CYC + LONG_PUSH_CYC;
	localparam int unsigned TW = ppc_pkg::TMR_W;

	// two-flop synchronisers; first stage read only by the second
	logic [4:0] sync1_r;
	logic [4:0] sync2_r;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			sync1_r <= 5'h1f;
			sync2_r <= 5'h1f;
		end else begin
			sync1_r <= {i_power_button_n, i_second_button_n, i_hold_confirm,
				i_above_upper, i_above_lower};
			sync2_r <= sync1_r;
		end
	end

	logic pb_low;
	logic sr_low;
	logic hold;
	logic vup;
	logic vlo_ok;
	assign pb_low = !sync2_r[4];
	assign sr_low = !sync2_r[3];
	assign hold = sync2_r[2];
	assign vup = sync2_r[1];
	assign vlo_ok = sync2_r[0];

	ppc_state_e state_r;
	logic [TW-1:0] deb_cnt_r;
	logic [TW-1:0] blank_cnt_r;
	logic [TW-1:0] rec_cnt_r;
	logic [TW-1:0] uv_cnt_r;
	logic [TW-1:0] lp_cnt_r;
	logic [TW-1:0] int_cnt_r;
	logic pb_prev_r;
	logic pressed_r;
	logic en_r;
	logic uv_r;
	logic lp_done_r;
	logic first_done_r;

	logic deb_done;
	logic pb_fall;
	logic blank_end;
	logic long_push;
	logic uv_long;
	assign deb_done = pb_low && (deb_cnt_r == TW'(DEBOUNCE_CYC - 1));
	assign pb_fall = pb_low && !pb_prev_r;
	assign blank_end = (state_r == PPC_START) && (blank_cnt_r == TW'(BLANK_CYC - 1));
	assign long_push = (lp_cnt_r == TW'(LONG_CYC)) && !lp_done_r;
	assign uv_long = uv_cnt_r == TW'(LONG_CYC);

	// button edge history
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pb_prev_r <= 1'b0;
		end else begin
			pb_prev_r <= pb_low;
		end
	end

	// debounce counter; restarts on release, and in the debounce state also on low supply
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			deb_cnt_r <= '0;
			pressed_r <= 1'b0;
		end else if (!pb_low) begin
			deb_cnt_r <= '0;
			pressed_r <= 1'b0;
		end else if (state_r == PPC_DEBOUNCE && !vup) begin
			deb_cnt_r <= '0;
		end else if (deb_done) begin
			pressed_r <= 1'b1;
		end else if (!pressed_r) begin
			deb_cnt_r <= deb_cnt_r + TW'(1);
		end
	end

	// main sequence: off, debounce, start-up blanking, run
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= PPC_OFF;
			en_r <= ppc_pkg::RST_EN;
			blank_cnt_r <= '0;
		end else begin
			case (state_r)
				PPC_OFF: begin
					en_r <= 1'b0;
					// standby waits on a falling edge only
					if (pb_fall) begin
						state_r <= PPC_DEBOUNCE;
					end
				end
				PPC_DEBOUNCE: begin
					if (!pb_low) begin
						state_r <= PPC_OFF;
					end else if (deb_done && vup) begin
						en_r <= 1'b1;
						blank_cnt_r <= '0;
						state_r <= PPC_START;
					end
				end
				PPC_START: begin
					blank_cnt_r <= blank_cnt_r + TW'(1);
					if (!pb_low && !hold && !first_done_r) begin
						en_r <= 1'b0;
						state_r <= PPC_OFF;
					end else if (blank_end) begin
						if (hold) begin
							state_r <= PPC_RUN;
						end else begin
							en_r <= 1'b0;
							state_r <= PPC_OFF;
						end
					end else if (!pb_low && hold && !first_done_r) begin
						state_r <= PPC_RUN;
					end
				end
				PPC_RUN: begin
					if (!hold || uv_long) begin
						en_r <= 1'b0;
						state_r <= PPC_OFF;
					end else if (long_push && !OPT_LONG_RESET) begin
						en_r <= 1'b0;
						state_r <= PPC_OFF;
					end else if (long_push) begin
						blank_cnt_r <= '0;
						state_r <= PPC_START;
					end
				end
				default: begin
					state_r <= PPC_OFF;
					en_r <= 1'b0;
				end
			endcase
		end
	end

	// start-up after a long-push reset has no first press to wait for
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			first_done_r <= 1'b0;
		end else if (state_r == PPC_RUN && long_push) begin
			first_done_r <= 1'b1;
		end else if (state_r != PPC_START) begin
			first_done_r <= 1'b0;
		end
	end

	// recovery reset pulse
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rec_cnt_r <= '0;
		end else if (state_r == PPC_DEBOUNCE && deb_done && vup) begin
			rec_cnt_r <= TW'(RECOVERY_CYC);
		end else if (state_r == PPC_RUN && long_push && OPT_LONG_RESET && hold && !uv_long) begin
			rec_cnt_r <= TW'(RECOVERY_CYC);
		end else if (rec_cnt_r != '0) begin
			rec_cnt_r <= rec_cnt_r - TW'(1);
		end
	end

	// undervoltage persistence timer, run state only
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			uv_r <= 1'b0;
			uv_cnt_r <= '0;
		end else if (state_r != PPC_RUN) begin
			uv_r <= 1'b0;
			uv_cnt_r <= '0;
		end else begin
			// count undervoltage time; hysteresis releases at upper level
			if (!vlo_ok) begin
				uv_r <= 1'b1;
			end else if (vup) begin
				uv_r <= 1'b0;
			end
			if (uv_r && !vup) begin
				if (uv_cnt_r != TW'(LONG_CYC)) begin
					uv_cnt_r <= uv_cnt_r + TW'(1);
				end
			end else begin
				uv_cnt_r <= '0;
			end
		end
	end

	// long push of both buttons, counted once per hold
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lp_cnt_r <= '0;
			lp_done_r <= 1'b0;
		end else if (state_r != PPC_RUN || !pb_low || !sr_low) begin
			lp_cnt_r <= '0;
			lp_done_r <= 1'b0;
		end else if (long_push) begin
			lp_done_r <= 1'b1;
		end else if (lp_cnt_r != TW'(LONG_CYC)) begin
			lp_cnt_r <= lp_cnt_r + TW'(1);
		end
	end

	// interrupt pulse stretcher; a new cause restarts width
	logic int_cause;
	logic int_hold;
	assign int_cause = (state_r == PPC_RUN) && ((deb_done && !pressed_r) || (!vlo_ok && !uv_r));
	assign int_hold = (state_r == PPC_RUN) && ((pressed_r && pb_low) || uv_r);
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_cnt_r <= '0;
			o_interrupt_n <= ppc_pkg::RST_N_OUT;
		end else if (int_cause) begin
			int_cnt_r <= TW'(INT_MIN_CYC - 1);
			o_interrupt_n <= 1'b0;
		end else if (int_cnt_r != '0) begin
			int_cnt_r <= int_cnt_r - TW'(1);
		end else begin
			o_interrupt_n <= !int_hold;
		end
	end

	// button state output with its own minimum width
	logic [TW-1:0] bs_cnt_r;
	logic bs_cause;
	logic bs_allowed;
	// report only in debounce or run, and not during undervoltage
	assign bs_allowed = !uv_r && (state_r == PPC_RUN || state_r == PPC_DEBOUNCE);
	assign bs_cause = bs_allowed && deb_done && !pressed_r;
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			bs_cnt_r <= '0;
			o_button_state_n <= ppc_pkg::RST_N_OUT;
		end else if (bs_cause) begin
			// low for at least minimum width
			bs_cnt_r <= TW'(INT_MIN_CYC - 1);
			o_button_state_n <= 1'b0;
		end else if (bs_cnt_r != '0) begin
			bs_cnt_r <= bs_cnt_r - TW'(1);
		end else if (!pb_low || state_r == PPC_OFF) begin
			o_button_state_n <= 1'b1;
		end
	end

	// registered pin outputs
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_power_enable <= OPT_EN_INVERT;
			o_reset_n <= ppc_pkg::RST_N_OUT;
			o_undervoltage_n <= ppc_pkg::RST_N_OUT;
			o_hold_pulldown <= 1'b0;
			o_ref_enable <= 1'b0;
			o_standby <= 1'b1;
		end else begin
			o_power_enable <= en_r ^ OPT_EN_INVERT;
			o_reset_n <= (rec_cnt_r == '0);
			o_undervoltage_n <= (state_r == PPC_RUN) ? !uv_r : vup;
			o_hold_pulldown <= (state_r == PPC_DEBOUNCE) || (state_r == PPC_START);
			// standby on and reference off while disabled
			o_ref_enable <= en_r && (rec_cnt_r == '0);
			o_standby <= !en_r;
		end
	end
endmodule : ppc_ctrl

`default_nettype wire

// [verilog/ppc_pkg.sv]
// shared constants for the push-button power controller
package ppc_pkg;
	// timebase: core clock is 50 MHz
	localparam int unsigned CLK_HZ = 50_000_000;
	// durations in microseconds, plain defaults
	localparam int unsigned DEBOUNCE_US = 30_000;
	localparam int unsigned INT_MIN_US = 30_000;
	localparam int unsigned RECOVERY_US = 360_000;
	localparam int unsigned BLANK_US = 2_000_000;
	localparam int unsigned LONG_PUSH_US = 5_000_000;
	// derived cycle counts, microseconds times whole cycles per microsecond
	localparam int unsigned CYC_PER_US = CLK_HZ / 1_000_000;
	localparam int unsigned DEBOUNCE_CYC = 32'(DEBOUNCE_US * CYC_PER_US);
	localparam int unsigned INT_MIN_CYC = 32'(INT_MIN_US * CYC_PER_US);
	localparam int unsigned RECOVERY_CYC = 32'(RECOVERY_US * CYC_PER_US);
	localparam int unsigned BLANK_CYC = 32'(BLANK_US * CYC_PER_US);
	localparam int unsigned LONG_PUSH_CYC = 32'(LONG_PUSH_US * CYC_PER_US);
	// timer width covers the largest count
	localparam int unsigned TMR_W = 32;
	// product options
	localparam bit OPT_LONG_RESET_DEFAULT = 1'b1;
	localparam bit OPT_EN_INVERT_DEFAULT = 1'b0;
	// reset values of outputs
	localparam bit RST_EN = 1'b0;
	localparam bit RST_N_OUT = 1'b1;
endpackage : ppc_pkg

// [bench/ppc_cpu_model.sv]
`timescale 1ns/1ns
`default_nettype none
// processor side: confirms power some cycles after leaving reset
module ppc_cpu_model (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// controller outputs and scenario commands
	input wire logic i_power_enable,
	input wire logic i_reset_n,
	input wire logic i_ack,
	input wire logic i_shutdown,
	// hold-confirm pin, low while not yet initialised
	output logic o_hold_confirm
);
	logic [3:0] init_r;
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			init_r <= 4'h0;
		end else if (!i_reset_n || !i_power_enable) begin
			init_r <= 4'h0;
		end else if (!init_r[3]) begin
			init_r <= init_r + 4'h1;
		end
	end
	// an unresponsive processor leaves the pin to the pull-down
	assign o_hold_confirm = i_ack && !i_shutdown && init_r[3];
endmodule : ppc_cpu_model
`default_nettype wire

// [bench/ppc_ctrl_assertions.sv]
`timescale 1ns/1ns
`default_nettype none
module ppc_chk #(
	parameter int unsigned INT_MIN_CYC = 1,
	parameter int unsigned RECOVERY_CYC = 1,
	parameter bit OPT_EN_INVERT = 1'b0
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_arst_n,
	// watched inputs
	input wire logic i_power_button_n,
	input wire logic i_hold_confirm,
	input wire logic i_above_upper,
	input wire logic i_above_lower,
	// watched outputs
	input wire logic o_power_enable,
	input wire logic o_reset_n,
	input wire logic o_interrupt_n,
	input wire logic o_hold_pulldown,
	input wire logic o_ref_enable,
	input wire logic o_standby
);
	logic [31:0] int_lo_r;
	logic [31:0] rst_lo_r;
	logic en_on;
	assign en_on = o_power_enable ^ OPT_EN_INVERT;
	// low-time counters, restarted whenever the line is high
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			int_lo_r <= '0;
			rst_lo_r <= '0;
		end else begin
			int_lo_r <= o_interrupt_n ? '0 : int_lo_r + 32'h1;
			rst_lo_r <= o_reset_n ? '0 : rst_lo_r + 32'h1;
		end
	end
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	startup_int_quiet_a: assert property (
		$rose(o_hold_pulldown) && $past(o_standby) |-> o_interrupt_n [*8]) else $error("int in startup");
	int_min_width_a: assert property (
		$rose(o_interrupt_n) && en_on |-> int_lo_r >= INT_MIN_CYC) else $error("int too short");
	reset_width_a: assert property (
		$rose(o_reset_n) && en_on |-> rst_lo_r == RECOVERY_CYC) else $error("reset width");
	enable_start_a: assert property (
		$rose(en_on) |-> !o_reset_n && o_hold_pulldown) else $error("start outputs");
	enable_supply_a: assert property (
		$rose(en_on) |-> $past(i_above_upper, 4) && $past(i_power_button_n, 4) == 1'b0)
		else $error("enable without cause");
	hold_drop_a: assert property (
		(en_on && !o_hold_pulldown && !i_hold_confirm) [*4] |-> ##[0:1] !en_on)
		else $error("hold low ignored");
	uv_int_a: assert property (
		(en_on && !o_hold_pulldown && !i_above_lower) [*4] |-> ##[0:1] !o_interrupt_n)
		else $error("uv int missing");
	standby_ref_a: assert property (
		o_standby |-> !o_ref_enable) else $error("ref on in standby");
endmodule : ppc_chk
bind ppc_ctrl ppc_chk #(.INT_MIN_CYC(INT_MIN_CYC), .RECOVERY_CYC(RECOVERY_CYC),
	.OPT_EN_INVERT(OPT_EN_INVERT)) chk_i (.i_core_clk(i_core_clk), .i_arst_n(i_arst_n),
	.i_power_button_n(i_power_button_n), .i_hold_confirm(i_hold_confirm),
	.i_above_upper(i_above_upper), .i_above_lower(i_above_lower),
	.o_power_enable(o_power_enable), .o_reset_n(o_reset_n), .o_interrupt_n(o_interrupt_n),
	.o_hold_pulldown(o_hold_pulldown), .o_ref_enable(o_ref_enable), .o_standby(o_standby));
`default_nettype wire

// [bench/ppc_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module testbench;
	// short counts keep the run brief
	localparam int DEB = 20;
	localparam int IMIN = 30;
	localparam int REC = 40;
	localparam int BLK = 400;
	localparam int LONG = DEB + IMIN + 50;
	logic clk = 1'b0, rst_n = 1'b0, pb_n = 1'b1, sr_n = 1'b1, up = 1'b1, lo = 1'b1;
	logic ack = 1'b0, shut = 1'b0;
	logic hold, en, rsn, int_n, bs_n, uv_n, pd, ref_en, sb;
	logic en_inv, rsn_inv, hold_inv;
	int n_errors = 0;
	int n_checks = 0;
	always #10 clk = ~clk;
	ppc_ctrl #(.DEBOUNCE_CYC(DEB), .INT_MIN_CYC(IMIN), .RECOVERY_CYC(REC), .BLANK_CYC(BLK),
		.LONG_PUSH_CYC(50)) dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_power_button_n(pb_n),
		.i_second_button_n(sr_n), .i_hold_confirm(hold), .i_above_upper(up), .i_above_lower(lo),
		.o_power_enable(en), .o_reset_n(rsn), .o_interrupt_n(int_n), .o_button_state_n(bs_n),
		.o_undervoltage_n(uv_n), .o_hold_pulldown(pd), .o_ref_enable(ref_en), .o_standby(sb));
	ppc_cpu_model cpu (.i_clk(clk), .i_arst_n(rst_n), .i_power_enable(en), .i_reset_n(rsn),
		.i_ack(ack), .i_shutdown(shut), .o_hold_confirm(hold));
	// second instance covers power-off on long push and the inverted enable
	ppc_ctrl #(.DEBOUNCE_CYC(DEB), .INT_MIN_CYC(IMIN), .RECOVERY_CYC(REC), .BLANK_CYC(BLK),
		.LONG_PUSH_CYC(50), .OPT_LONG_RESET(1'b0), .OPT_EN_INVERT(1'b1)) dut_inv (
		.i_core_clk(clk), .i_arst_n(rst_n), .i_power_button_n(pb_n), .i_second_button_n(sr_n),
		.i_hold_confirm(hold_inv), .i_above_upper(up), .i_above_lower(lo),
		.o_power_enable(en_inv), .o_reset_n(rsn_inv), .o_interrupt_n(), .o_button_state_n(),
		.o_undervoltage_n(), .o_hold_pulldown(), .o_ref_enable(), .o_standby());
	ppc_cpu_model cpu_inv (.i_clk(clk), .i_arst_n(rst_n), .i_power_enable(!en_inv),
		.i_reset_n(rsn_inv), .i_ack(ack), .i_shutdown(shut), .o_hold_confirm(hold_inv));
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	task automatic chk(input logic got, input logic exp);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %b want %b", $time, got, exp);
		end
	endtask : chk
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	// bounded wait on enable or reset; running out ends the run
	task automatic wait_lvl(input bit on_rst, input logic v, input int lim);
		for (int k = 0; k < lim && (on_rst ? rsn : en) !== v; k++) cyc(1);
		if ((on_rst ? rsn : en) !== v) begin
			n_errors++;
			$display("[ERR] %0t wait ran out", $time);
			test_done();
		end
	endtask : wait_lvl
	// start-up with the button held; ok says whether the processor confirms
	task automatic power_up(input logic ok);
		ack = ok;
		wait_lvl(0, 1'b1, DEB + 8);
		chk(rsn, 1'b0);
		chk(pd, 1'b1);
		chk(int_n, 1'b1);
		wait_lvl(1, 1'b1, REC + 4);
		cyc(14);
		pb_n = 1'b1;
		cyc(6);
		chk(en, ok);
		chk(en_inv, !ok);
		chk(ref_en, ok);
	endtask : power_up
	// short press refused, then a supply dip restarts the debounce
	task automatic t_dip;
		pb_n = 1'b0;
		cyc(DEB - 4);
		pb_n = 1'b1;
		cyc(DEB);
		chk(en, 1'b0);
		pb_n = 1'b0;
		cyc(DEB / 2);
		up = 1'b0;
		cyc(4);
		up = 1'b1;
		cyc(DEB - 2);
		chk(en, 1'b0);
		power_up(1'b1);
	endtask : t_dip
	// press in run, released before the minimum width
	task automatic t_press;
		pb_n = 1'b0;
		cyc(DEB + 5);
		chk(int_n, 1'b0);
		chk(bs_n, 1'b0);
		pb_n = 1'b1;
		cyc(IMIN - 12);
		chk(int_n, 1'b0);
		chk(bs_n, 1'b0);
		cyc(18);
		chk(int_n, 1'b1);
		chk(bs_n, 1'b1);
	endtask : t_press
	// undervoltage, short or beyond the long limit
	task automatic t_uv(input bit long_uv);
		lo = 1'b0;
		up = 1'b0;
		cyc(6);
		chk(int_n, 1'b0);
		chk(uv_n, 1'b0);
		cyc(LONG - 16);
		chk(en, 1'b1);
		cyc(long_uv ? 20 : 0);
		chk(en, !long_uv);
		lo = 1'b1;
		up = 1'b1;
		cyc(IMIN + 5);
		chk(uv_n, 1'b1);
		chk(int_n, 1'b1);
	endtask : t_uv
	// two-button long push: reset pulse, then blanking with hold confirmed
	task automatic t_long;
		pb_n = 1'b0;
		sr_n = 1'b0;
		cyc(LONG - 10);
		chk(rsn, 1'b1);
		wait_lvl(1, 1'b0, 25);
		chk(en, 1'b1);
		chk(en_inv, 1'b1);
		pb_n = 1'b1;
		sr_n = 1'b1;
		cyc(BLK + 20);
		chk(en, 1'b1);
		shut = 1'b1;
		cyc(5);
		chk(en, 1'b0);
		chk(sb, 1'b1);
		shut = 1'b0;
	endtask : t_long
	// held past blanking without confirm: power drops at blanking end
	task automatic t_blank;
		ack = 1'b0;
		pb_n = 1'b0;
		wait_lvl(0, 1'b1, DEB + 8);
		cyc(BLK / 2);
		chk(en, 1'b1);
		wait_lvl(0, 1'b0, BLK);
		pb_n = 1'b1;
	endtask : t_blank
	initial begin
		cyc(2);
		rst_n = 1'b1;
		t_dip();
		t_press();
		t_uv(1'b0);
		t_long();
		pb_n = 1'b0;
		power_up(1'b0);
		t_blank();
		cyc(10);
		pb_n = 1'b0;
		power_up(1'b1);
		t_uv(1'b1);
		test_done();
	end
endmodule : testbench
`default_nettype wire
